// ==== rtl/external_bus_unit.sv ====
// External bus unit: bus modes, windows, chip selects, ready and arbitration.
`timescale 1ns/1ps
module external_bus_unit (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Core access port.
   input wire logic req_valid,
   input wire ebu_pkg::bus_req_s req,
   output logic req_ready,
   output logic resp_valid,
   output logic [15:0] resp_rdata,
   // Configuration.
   input wire logic single_chip_mode,
   input wire ebu_pkg::addr_space_e addr_space,
   input wire logic [15:0] system_config_reg,
   input wire ebu_pkg::bus_cfg_s default_bus_config,
   input wire ebu_pkg::bus_cfg_s [4:1] window_bus_config,
   input wire ebu_pkg::win_sel_s [4:1] window_address_select,
   input wire logic arbitration_enable,
   input wire logic slave_select_dir_bit,
   // External bus pins.
   input wire logic [15:0] muxed_addr_data_in,
   output logic [15:0] muxed_addr_data_port,
   output logic [15:0] muxed_addr_data_oe,
   output logic [15:0] address_port,
   output logic [7:0] segment_port,
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic [4:0] cs_n,
   output logic bus_oe,
   input wire logic ready_n,
   // Arbitration pins.
   input wire logic hold_n,
   input wire logic hold_acknowledge_n_in,
   output logic hold_acknowledge_n,
   output logic hold_acknowledge_n_oe,
   output logic bus_request_out_n
);
   import ebu_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_ALE, S_DLY, S_CMD, S_TRI} state_e;

   typedef struct packed {
      state_e st;
      logic [3:0] cnt;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic wr;
      bus_cfg_s cfg;
      logic [2:0] win;
      logic ale;
      logic rdn;
      logic wrn;
      logic [4:0] csn;
      logic [15:0] ad;
      logic [15:0] adoe;
      logic [15:0] aport;
      logic [7:0] seg;
      logic dmx;
      logic own;
      logic rdy;
      logic resp;
      logic [15:0] rdata;
   } ebu_state_s;

   ebu_state_s s_reg;
   ebu_state_s s_next;
   logic acc;
   logic bus_idle;
   logic away_next;
   logic chip_select_unlatched_cfg;
   logic [23:0] dec_addr;
   logic [4:1] dhit;
   logic [2:0] didx;
   bus_cfg_s dcfg;
   logic [4:0] cs_hot;

   ////////////////////////////////////////////////////////////////////////////
   // Window decode and arbitration.

   // One decoder serves the new request or the address being held on the bus.
   assign acc = req_valid && s_reg.rdy;
   assign bus_idle = (s_reg.st == S_IDLE) && !acc;
   assign dec_addr = acc ? req.addr : s_reg.addr;
   assign chip_select_unlatched_cfg = system_config_reg[CS_CFG_BIT];
   assign dcfg = (didx == 3'h0) ? default_bus_config : window_bus_config[didx];
   assign cs_hot = 5'(5'h01 << didx);

   window_decode u_dec (
      .addr(dec_addr),
      .sel(window_address_select),
      .cfg(window_bus_config),
      .hit(dhit),
      .idx(didx)
   );

   bus_arbiter u_arb (
      .clk(clk),
      .rst(rst),
      .arbitration_enable(arbitration_enable),
      .slave_select_dir_bit(slave_select_dir_bit),
      .bus_idle(bus_idle),
      .pending(req_valid),
      .away_next(away_next),
      .hold_n(hold_n),
      .hold_acknowledge_n_in(hold_acknowledge_n_in),
      .hold_acknowledge_n(hold_acknowledge_n),
      .hold_acknowledge_n_oe(hold_acknowledge_n_oe),
      .bus_request_out_n(bus_request_out_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer.

   // Each access runs latch strobe, optional delay, command with waits, optional float time.
   always_comb begin
      s_next = s_reg;
      s_next.resp = 1'b0;
      case (s_reg.st)
         S_IDLE: begin
            if (acc) begin
               s_next.addr = req.addr;
               s_next.wdata = req.wdata;
               s_next.wr = req.write;
               s_next.cfg = dcfg;
               s_next.win = didx;
               s_next.ale = 1'b1;
               s_next.cnt = dcfg.ale_ext ? ALE_EXT_CYC : 4'h0;
               s_next.st = S_ALE;
               if (is_mux(dcfg.mode)) begin
                  s_next.ad = req.addr[15:0];
                  s_next.adoe = OE_ALL;
               end else begin
                  s_next.dmx = 1'b1;
               end
               if (!chip_select_unlatched_cfg && dcfg.cs_en) begin
                  s_next.csn = ~cs_hot;
               end
            end
         end
         S_ALE: begin
            if (s_reg.cnt != 4'h0) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               s_next.ale = 1'b0;
               // Data phase: writes drive the port, reads float it.
               if (s_reg.wr) begin
                  s_next.ad = s_reg.wdata;
                  s_next.adoe = is_byte(s_reg.cfg.mode) ? OE_LOW : OE_ALL;
               end else begin
                  s_next.adoe = 16'h0000;
               end
               if (s_reg.cfg.rw_dly) begin
                  s_next.st = S_DLY;
                  s_next.cnt = RW_DLY_CYC - 4'h1;
               end else begin
                  s_next.st = S_CMD;
                  s_next.cnt = s_reg.cfg.wait_cyc;
                  s_next.rdn = s_reg.wr;
                  s_next.wrn = !s_reg.wr;
               end
            end
         end
         S_DLY: begin
            if (s_reg.cnt != 4'h0) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               s_next.st = S_CMD;
               s_next.cnt = s_reg.cfg.wait_cyc;
               s_next.rdn = s_reg.wr;
               s_next.wrn = !s_reg.wr;
            end
         end
         S_CMD: begin
            if (s_reg.cnt != 4'h0) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else if (!(s_reg.cfg.rdy_en && ready_n)) begin
               s_next.rdn = 1'b1;
               s_next.wrn = 1'b1;
               s_next.adoe = 16'h0000;
               s_next.resp = 1'b1;
               s_next.rdata = is_byte(s_reg.cfg.mode) ? {8'h00, muxed_addr_data_in[7:0]} : muxed_addr_data_in;
               if (!chip_select_unlatched_cfg) begin
                  s_next.csn = CS_IDLE;
               end
               if (s_reg.cfg.tri_ext) begin
                  s_next.st = S_TRI;
                  s_next.cnt = TRI_CYC - 4'h1;
               end else begin
                  s_next.st = S_IDLE;
               end
            end
         end
         S_TRI: begin
            if (s_reg.cnt != 4'h0) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               s_next.st = S_IDLE;
            end
         end
         default: begin
            s_next.st = S_IDLE;
         end
      endcase
      // Address port follows the address once a demultiplexed access has run.
      if (s_next.dmx) begin
         s_next.aport = s_next.addr[15:0];
      end
      s_next.seg = s_next.addr[23:16] & seg_mask(addr_space);
      s_next.own = !away_next && !single_chip_mode;
      // Unlatched selects follow the decoded address while the bus is owned and the decoded range enables its select.
      if (chip_select_unlatched_cfg) begin
         s_next.csn = (s_next.own && dcfg.cs_en) ? ~cs_hot : CS_IDLE;
      end
      s_next.rdy = (s_next.st == S_IDLE) && s_next.own;
   end

   // State register; strobes and selects inactive after reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.rdn <= 1'b1;
         s_reg.wrn <= 1'b1;
         s_reg.csn <= CS_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // All outputs come from the state register.
   assign req_ready = s_reg.rdy;
   assign resp_valid = s_reg.resp;
   assign resp_rdata = s_reg.rdata;
   assign muxed_addr_data_port = s_reg.ad;
   assign muxed_addr_data_oe = s_reg.adoe;
   assign address_port = s_reg.aport;
   assign segment_port = s_reg.seg;
   assign ale = s_reg.ale;
   assign rd_n = s_reg.rdn;
   assign wr_n = s_reg.wrn;
   assign cs_n = s_reg.csn;
   assign bus_oe = s_reg.own;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_single_chip: assert property (single_chip_mode |=> !bus_oe && !req_ready)
      else $error("bus used in single-chip mode");
   a_demux_addr: assert property (s_reg.dmx && s_reg.st != S_IDLE |-> address_port == s_reg.addr[15:0])
      else $error("address port lost the address");
   a_byte_data: assert property (s_reg.st == S_CMD && s_reg.wr && s_reg.cfg.mode == MODE_DEMUX8
      |-> muxed_addr_data_oe == OE_LOW)
      else $error("8-bit write drives the high byte");
   a_mux_addr: assert property ($rose(ale) && is_mux(s_reg.cfg.mode)
      |-> muxed_addr_data_oe == OE_ALL && muxed_addr_data_port == s_reg.addr[15:0])
      else $error("multiplexed address phase wrong");
   a_ale_length: assert property ($rose(ale) && s_reg.cfg.ale_ext |=> ale ##1 !ale)
      else $error("extended latch strobe length wrong");
   a_wait_hold: assert property (s_reg.st == S_CMD && s_reg.cnt != 4'h0 |=> s_reg.st == S_CMD && $stable(rd_n))
      else $error("command ended before its wait states");
   a_win_prio: assert property (acc && dhit[4] || acc && dhit[2] && !dhit[3] && !dhit[4]
      |=> s_reg.win == (dhit[4] ? 3'h4 : 3'h2))
      else $error("window priority wrong");
   a_default_cfg: assert property (acc && dhit == 4'h0
      |=> s_reg.win == 3'h0 && s_reg.cfg == $past(default_bus_config))
      else $error("default configuration not used");
   a_cs_select: assert property (acc && !chip_select_unlatched_cfg && dcfg.cs_en |=> !cs_n[s_reg.win])
      else $error("chip select not asserted");
   a_cs_unlatched: assert property (chip_select_unlatched_cfg && bus_idle && s_reg.own && dcfg.cs_en
      && !away_next |=> !cs_n[$past(didx)])
      else $error("unlatched select not decoded");
   a_ready_wait: assert property (s_reg.st == S_CMD && s_reg.cnt == 4'h0 && s_reg.cfg.rdy_en && ready_n
      |=> s_reg.st == S_CMD && !resp_valid)
      else $error("access ended without ready");
   a_seg_lines: assert property (s_reg.st != S_IDLE && $stable(addr_space)
      |-> segment_port == (s_reg.addr[23:16] & seg_mask(addr_space)))
      else $error("segment lines wrong");
   a_cs_stable: assert property (s_reg.st == S_CMD && !chip_select_unlatched_cfg
      && $stable(chip_select_unlatched_cfg) |-> $stable(cs_n))
      else $error("latched select moved in a cycle");

   c_mux_read: cover property (acc && !req.write && is_mux(dcfg.mode) ##[3:40] resp_valid);
   c_ready_wait: cover property (s_reg.st == S_CMD && s_reg.cfg.rdy_en && ready_n ##1 resp_valid);
   c_away: cover property (!bus_oe ##1 bus_oe);

endmodule

// ==== rtl/ebu_pkg.sv ====
// Shared types and constants of the external bus unit.
package ebu_pkg;

   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int NUM_WIN = 4;
   localparam int CS_CFG_BIT = 6;
   localparam logic [3:0] ALE_EXT_CYC = 4'h1;
   localparam logic [3:0] RW_DLY_CYC = 4'h1;
   localparam logic [3:0] TRI_CYC = 4'h1;
   localparam logic [4:0] CS_IDLE = 5'h1F;
   localparam logic [15:0] OE_ALL = 16'hFFFF;
   localparam logic [15:0] OE_LOW = 16'h00FF;
   localparam logic [7:0] SEG_MASK_16M = 8'hFF;
   localparam logic [7:0] SEG_MASK_1M = 8'h0F;
   localparam logic [7:0] SEG_MASK_256K = 8'h03;
   localparam logic [7:0] SEG_MASK_64K = 8'h00;

   typedef enum logic [1:0] {MODE_DEMUX16, MODE_MUX16, MODE_MUX8, MODE_DEMUX8} bus_mode_e;
   typedef enum logic [1:0] {SPACE_64K, SPACE_256K, SPACE_1M, SPACE_16M} addr_space_e;

   // Window base in 4 KByte units and its size as a power of two of that unit.
   typedef struct packed {
      logic [11:0] base;
      logic [3:0] size;
   } win_sel_s;

   // Bus characteristics of one address range.
   typedef struct packed {
      logic act;
      bus_mode_e mode;
      logic [3:0] wait_cyc;
      logic tri_ext;
      logic ale_ext;
      logic rw_dly;
      logic rdy_en;
      logic cs_en;
   } bus_cfg_s;

   // One access from the core.
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;

   // Upper address lines kept for each address space size.
   function automatic logic [7:0] seg_mask(addr_space_e sp);
      case (sp)
         SPACE_16M: seg_mask = SEG_MASK_16M;
         SPACE_1M: seg_mask = SEG_MASK_1M;
         SPACE_256K: seg_mask = SEG_MASK_256K;
         default: seg_mask = SEG_MASK_64K;
      endcase
   endfunction

   function automatic logic is_mux(bus_mode_e m);
      return (m == MODE_MUX16) || (m == MODE_MUX8);
   endfunction

   function automatic logic is_byte(bus_mode_e m);
      return (m == MODE_MUX8) || (m == MODE_DEMUX8);
   endfunction

endpackage

// ==== rtl/window_decode.sv ====
// Address window decoder with fixed window priority.
`timescale 1ns/1ps
module window_decode (
   // Address to classify.
   input wire logic [23:0] addr,
   // Window settings.
   input wire ebu_pkg::win_sel_s [4:1] sel,
   input wire ebu_pkg::bus_cfg_s [4:1] cfg,
   // Result.
   output logic [4:1] hit,
   output logic [2:0] idx
);
   import ebu_pkg::*;

   // Each enabled window compares the address bits above its size.
   for (genvar i = 1; i <= NUM_WIN; i++) begin : g_win
      logic [12:0] span;
      assign span = 13'(13'h0001 << sel[i].size) - 13'h0001;
      assign hit[i] = cfg[i].act && (((addr[23:12] ^ sel[i].base) & ~span[11:0]) == 12'h000);
   end

   // Higher windows override lower ones; no hit falls to the default range.
   always_comb begin
      idx = 3'h0;
      for (int i = 1; i <= NUM_WIN; i++) begin
         if (hit[i]) begin
            idx = 3'(i);
         end
      end
   end

endmodule

// ==== rtl/bus_arbiter.sv ====
// Hold and hold-acknowledge arbitration of the external bus.
`timescale 1ns/1ps
module bus_arbiter (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control.
   input wire logic arbitration_enable,
   input wire logic slave_select_dir_bit,
   // Bus unit status.
   input wire logic bus_idle,
   input wire logic pending,
   output logic away_next,
   // Arbitration pins.
   input wire logic hold_n,
   input wire logic hold_acknowledge_n_in,
   output logic hold_acknowledge_n,
   output logic hold_acknowledge_n_oe,
   output logic bus_request_out_n
);
   typedef struct packed {
      logic on;
      logic away;
      logic ack_n;
      logic ack_oe;
      logic bus_req_n;
   } arb_state_s;

   arb_state_s s_reg;
   arb_state_s s_next;
   logic slave;

   assign slave = slave_select_dir_bit;

   // The bus is only handed over between accesses, never in the middle of one.
   always_comb begin
      s_next = s_reg;
      s_next.on = s_reg.on | arbitration_enable;
      if (!s_next.on) begin
         s_next.away = 1'b0;
      end else if (!slave) begin
         s_next.away = !hold_n && (s_reg.away || bus_idle);
      end else begin
         s_next.away = hold_acknowledge_n_in && (s_reg.away || bus_idle);
      end
      s_next.ack_oe = s_next.on && !slave;
      s_next.ack_n = !(s_next.on && !slave && s_next.away);
      s_next.bus_req_n = !(s_next.on && s_next.away && pending);
   end

   // State register; arbitration off and acknowledge pin undriven after reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ack_n <= 1'b1;
         s_reg.bus_req_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign away_next = s_next.away;
   assign hold_acknowledge_n = s_reg.ack_n;
   assign hold_acknowledge_n_oe = s_reg.ack_oe;
   assign bus_request_out_n = s_reg.bus_req_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_master_grant: assert property (s_reg.on && !slave && !hold_n && bus_idle |=> !hold_acknowledge_n)
      else $error("hold request at idle not acknowledged");
   a_slave_input: assert property (slave_select_dir_bit |=> !hold_acknowledge_n_oe)
      else $error("acknowledge pin driven in slave mode");
   a_no_snatch: assert property (!s_reg.away && !bus_idle |=> !s_reg.away)
      else $error("bus given away during an access");
   c_hold_grant: cover property (!hold_acknowledge_n ##1 hold_acknowledge_n);

endmodule

// ==== test/ext_mem_model.sv ====
// Behavioural external memory with a programmable ready delay.
`timescale 1ns/1ps
module ext_mem_model (
   // Clock.
   input wire logic clk,
   // Bus pins.
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [15:0] bus_wire,
   input wire logic [15:0] address_port,
   // Setup from the bench.
   input wire logic demux,
   input wire logic [3:0] stall,
   // Answer.
   output logic [15:0] drive,
   output logic ready_n
);
   logic [15:0] mem [0:255];
   logic [7:0] addr_reg;
   logic [3:0] cnt_reg = 4'h0;
   logic [15:0] last_reg = 16'h0;
   // Latch the address, store written words and count command cycles.
   always_ff @(posedge clk) begin
      if (ale) begin
         addr_reg <= demux ? address_port[7:0] : bus_wire[7:0];
      end
      if (!wr_n) begin
         mem[addr_reg] <= bus_wire;
      end
      cnt_reg <= (!rd_n || !wr_n) ? cnt_reg + 4'h1 : 4'h0;
      // A free-running pattern, so an unknown strobe at start-up cannot stick in it.
      last_reg <= {last_reg[14:0], ~last_reg[15]};
   end
   // Drive read data only under the read strobe; otherwise a pattern that changes each cycle.
   assign drive = !rd_n ? mem[addr_reg] : ~last_reg;
   // Ready comes after the programmed number of command cycles.
   assign ready_n = !((!rd_n || !wr_n) && cnt_reg >= stall);
endmodule

// ==== test/testbench.sv ====
// Self-checking testbench of the external bus unit.
`timescale 1ns/1ps
module testbench;
   import ebu_pkg::*;
   logic clk, rst, req_valid, req_ready, resp_valid, single_chip_mode, arbitration_enable, slave_select_dir_bit;
   logic ale, rd_n, wr_n, bus_oe, ready_n, hold_n, hold_acknowledge_n_in, hold_acknowledge_n, demux, cs_bad;
   logic hold_acknowledge_n_oe, bus_request_out_n;
   bus_req_s req;
   addr_space_e addr_space;
   bus_cfg_s default_bus_config;
   bus_cfg_s [4:1] window_bus_config;
   win_sel_s [4:1] window_address_select;
   logic [15:0] resp_rdata, system_config_reg, port, oe, address_port, drive, bus_wire;
   logic [15:0] a_seen, p_seen, wd_seen, oe_seen, rdata;
   logic [7:0] segment_port, s_seen;
   logic [4:0] cs_n;
   logic [3:0] stall;
   int err_count, num_checks, lat;
   external_bus_unit i_external_bus_unit (.clk, .rst, .req_valid, .req, .req_ready, .resp_valid, .resp_rdata,
      .single_chip_mode, .addr_space, .system_config_reg, .default_bus_config, .window_bus_config,
      .window_address_select, .arbitration_enable, .slave_select_dir_bit, .muxed_addr_data_in(bus_wire),
      .muxed_addr_data_port(port), .muxed_addr_data_oe(oe), .address_port, .segment_port, .ale, .rd_n, .wr_n,
      .cs_n, .bus_oe, .ready_n, .hold_n, .hold_acknowledge_n_in, .hold_acknowledge_n, .hold_acknowledge_n_oe,
      .bus_request_out_n);
   ext_mem_model i_ext_mem_model (.clk, .ale, .rd_n, .wr_n, .bus_wire, .address_port, .demux, .stall, .drive,
      .ready_n);
   // Wire level of the shared port from both drivers.
   assign bus_wire = (port & oe) | (drive & ~oe);
   //////////////////////////////////////////////////////////////////////////
   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      $display("mismatch watchdog expected finish seen timeout");
      err_count++;
      test_done();
   end
   //////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic bus_cfg_s cfg(bus_mode_e m, logic [3:0] w, logic [3:0] opt);
      return '{1'b1, m, w, opt[3], opt[2], opt[1], opt[0], 1'b1};
   endfunction
   task automatic use_cfg(input bus_cfg_s c);
      default_bus_config = c;
      demux = (c.mode == MODE_DEMUX16) || (c.mode == MODE_DEMUX8);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One access; records latency, phases and chip-select steadiness.
   task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [4:0] cse);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      req_valid = 1'b1;
      req = '{w, a, d};
      @(negedge clk);
      req_valid = 1'b0;
      // The cycle right after the take edge counts as cycle one.
      lat = 1;
      cs_bad = 1'b0;
      while (resp_valid !== 1'b1 && lat < 60) begin
         if (ale === 1'b1) begin
            a_seen = port;
            p_seen = address_port;
            s_seen = segment_port;
         end
         if ((rd_n === 1'b0 || wr_n === 1'b0) && cs_n !== cse) cs_bad = 1'b1;
         if (wr_n === 1'b0) begin
            wd_seen = port;
            oe_seen = oe;
         end
         @(negedge clk);
         lat++;
      end
      rdata = resp_rdata;
      chk("resp_valid", 1, resp_valid);
   endtask
   task automatic do_reset;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      chk("cs_n", 5'h1F, cs_n);
      chk("hold_ack_oe", 0, hold_acknowledge_n_oe);
      chk("strobes", 3'b110, {rd_n, wr_n, bus_oe});
      rst = 1'b0;
      @(negedge clk);
      chk("bus_oe", 1, bus_oe);
      $display("test reset done");
   endtask
   task automatic t_mux;
      use_cfg(cfg(MODE_MUX16, 4'h0, 4'h0));
      acc(1'b1, 24'h000012, 16'hA5C3, 5'h1E);
      chk("lat", 3, lat);
      chk("addr", 16'h0012, a_seen);
      chk("wdata", 16'hA5C3, wd_seen);
      chk("oe", 16'hFFFF, oe_seen);
      chk("cs", 0, cs_bad);
      acc(1'b0, 24'h000012, 16'h0000, 5'h1E);
      chk("rdata", 16'hA5C3, rdata);
      $display("test mux done");
   endtask
   task automatic t_modes;
      logic byte_m, dmx;
      for (int i = 0; i < 4; i++) begin
         byte_m = (i == 2) || (i == 3);
         dmx = (i == 0) || (i == 3);
         use_cfg(cfg(bus_mode_e'(i), 4'h0, 4'h0));
         acc(1'b1, 24'h000020 + i, 16'hBEEF, 5'h1E);
         chk("oe", byte_m ? 16'h00FF : 16'hFFFF, oe_seen);
         chk("addr", 16'h0020 + i, dmx ? p_seen : a_seen);
         acc(1'b0, 24'h000020 + i, 16'h0000, 5'h1E);
         chk("rdata", byte_m ? 16'h00EF : 16'hBEEF, rdata);
      end
      use_cfg(cfg(MODE_MUX16, 4'h0, 4'h0));
      acc(1'b0, 24'h000044, 16'h0000, 5'h1E);
      chk("addr_port", 16'h0044, p_seen);
      $display("test modes done");
   endtask
   task automatic t_win;
      logic [23:0] adr [5] = '{24'h100010, 24'h108010, 24'h201010, 24'h200020, 24'h300030};
      int idx [5] = '{1, 2, 3, 4, 0};
      window_address_select = {win_sel_s'({12'h200, 4'h0}), win_sel_s'({12'h200, 4'h4}),
         win_sel_s'({12'h108, 4'h0}), win_sel_s'({12'h100, 4'h4})};
      for (int k = 1; k <= 4; k++) window_bus_config[k] = cfg(MODE_MUX16, 4'(k), 4'h0);
      for (int j = 0; j < 2; j++) begin
         system_config_reg = j ? 16'h0040 : 16'h0000;
         for (int i = 0; i < 5; i++) begin
            acc(1'b1, adr[i], 16'h1234, ~(5'h01 << idx[i]));
            chk("cs", 0, cs_bad);
            chk("lat", 3 + idx[i], lat);
         end
      end
      system_config_reg = 16'h0000;
      $display("test windows done");
   endtask
   task automatic t_timing;
      use_cfg(cfg(MODE_MUX16, 4'h2, 4'b1110));
      acc(1'b0, 24'h000012, 16'h0000, 5'h1E);
      chk("lat", 7, lat);
      chk("float", 0, req_ready);
      chk("rdata", 16'hA5C3, rdata);
      stall = 4'h3;
      use_cfg(cfg(MODE_MUX16, 4'h0, 4'b0001));
      acc(1'b0, 24'h000012, 16'h0000, 5'h1E);
      chk("ready_lat", 6, lat);
      chk("ready_rdata", 16'hA5C3, rdata);
      stall = 4'h0;
      $display("test timing done");
   endtask
   task automatic t_seg;
      logic [7:0] msk [4] = '{8'h00, 8'h03, 8'h0F, 8'hFF};
      use_cfg(cfg(MODE_MUX16, 4'h0, 4'h0));
      for (int i = 0; i < 4; i++) begin
         addr_space = addr_space_e'(i);
         acc(1'b0, 24'hAB0012, 16'h0000, 5'h1E);
         chk("segment", 8'hAB & msk[i], s_seen);
      end
      $display("test segment done");
   endtask
   task automatic t_arb;
      arbitration_enable = 1'b1;
      hold_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("hold_ack", 3'b010, {hold_acknowledge_n, hold_acknowledge_n_oe, bus_oe});
      req_valid = 1'b1;
      req = '{1'b0, 24'h000012, 16'h0000};
      repeat (2) @(negedge clk);
      chk("bus_req", 2'b00, {bus_request_out_n, req_ready});
      hold_n = 1'b1;
      req_valid = 1'b0;
      repeat (2) @(negedge clk);
      chk("back", 2'b11, {hold_acknowledge_n, bus_oe});
      slave_select_dir_bit = 1'b1;
      hold_acknowledge_n_in = 1'b1;
      repeat (3) @(negedge clk);
      chk("slave", 2'b00, {hold_acknowledge_n_oe, bus_oe});
      hold_acknowledge_n_in = 1'b0;
      repeat (3) @(negedge clk);
      chk("granted", 1, bus_oe);
      $display("test arbitration done");
   endtask
   task automatic t_single;
      single_chip_mode = 1'b1;
      do_reset();
      @(negedge clk);
      chk("single", 2'b00, {req_ready, bus_oe});
      $display("test single chip done");
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      single_chip_mode = 1'b0;
      addr_space = SPACE_16M;
      system_config_reg = 16'h0000;
      window_bus_config = '0;
      window_address_select = '0;
      arbitration_enable = 1'b0;
      slave_select_dir_bit = 1'b0;
      hold_n = 1'b1;
      hold_acknowledge_n_in = 1'b1;
      stall = 4'h0;
      err_count = 0;
      num_checks = 0;
      use_cfg(cfg(MODE_MUX16, 4'h0, 4'h0));
      t_reset();
      t_mux();
      t_modes();
      t_win();
      t_timing();
      t_seg();
      t_arb();
      t_single();
      test_done();
   end
endmodule
